//--- axis_sync_map.vh
`ifndef AXIS_SYNC_MAP_VH
`define AXIS_SYNC_MAP_VH
// ==========================================
// Register offsets (byte addresses)
`define REG_CMD 8'h00
`define REG_CFG 8'h04
`define REG_INCH_AMT 8'h08
`define REG_INCH_SPEED 8'h0c
`define REG_JOG_ACC 8'h10
`define REG_JOG_DEC 8'h14
`define REG_RATIO 8'h18
`define REG_SPEED_LIMIT 8'h1c
`define REG_ESTOP_DEC 8'h20
`define REG_SYNC_POS 8'h24
`define REG_SYNC_STEP 8'h28
`define REG_ENC_MAX 8'h2c
`define REG_ENC_MIN 8'h30
`define REG_STATUS 8'h34
`define REG_ENC_COUNT 8'h38
`define REG_POS_X 8'h3c
`define REG_POS_Y 8'h40
`define REG_ERR 8'h44
// ==========================================
// Command register bits
`define CMD_INCH 0
`define CMD_SPD_SYNC 1
`define CMD_SYNC_RELEASE 2
`define CMD_POS_SYNC 3
`define CMD_STOP 4
`define CMD_AUX_RELEASE 5
// ==========================================
// Configuration fields
`define CFG_AXIS 0
`define CFG_MASTER_LSB 1
`define CFG_ENC_MODE_LSB 3
`define ENC_UPDOWN 2'h0
`define ENC_PULSE_DIR 2'h1
`define ENC_QUAD4 2'h2
`define MASTER_ENC 2'h2
// ==========================================
// Reset values
`define RST_RATIO 32'h0001_0001
`define RST_INCH_SPEED 16'h0001
`define RST_SPEED_LIMIT 32'h0001_86a0
`define RST_ENC_MAX 32'h7fff_ffff
`define RST_ENC_MIN 32'h8000_0001
`define RST_SYNC_STEP 8'h01
// ==========================================
// Error codes
`define ERR_AUX_ON_SPD 16'h0161
`define ERR_AUX_ON_POS 16'h0157
`define ERR_MASTER 16'h0163
`define ERR_OVERSPEED 16'h0165
`define ERR_INCH_SPEED 16'h0190
`define ERR_NO_ORIGIN 16'h0191
// ==========================================
// Timing
`define CLK_PERIOD_NS 20
`define CLK_HZ 50000000
`define MS_NS 1000000
`define MS_CYC (`MS_NS / `CLK_PERIOD_NS)
`define RATE_WIN_NS 1000000000
`define RATE_WIN_CYC (`RATE_WIN_NS / `CLK_PERIOD_NS)
`define DIST_SCALE 2000
`endif

//--- axis_inching_and_sync_control.v
// Summary of operation
// - Inching amount is full signed 32-bit count
// - Positive amount forward, negative amount reverse
// - Inching ramps with jog acc/dec times
// - Inching speed 1..65535, else error, no move
// - Jog acc/dec times 0..65535 drive inching
// - Sub axis follows main start, stop, direction
// - Speed sync stays operating until release, stop or master overspeed
// - Sub speed equals main times sub/main
// - Speed sync with aux code on: error
// - Invalid or same master axis: error
// - Master overspeed: error, emergency decelerate
// - Encoder master: start on first pulse
// - Quadrature: A leads forward, B leads reverse
// - Encoder modes updown, pulse/dir, quadrature x4
// - Encoder count clamped to max/min
// - Position sync only with master origin set
// - Position sync marks busy, starts at position
// - Stop cancels pending position sync
// - Trigger when position passed between scans
//
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "axis_sync_map.vh"
module axis_inching_and_sync_control #(
  parameter MS_CYC = `MS_CYC,
  parameter RATE_WIN_CYC = `RATE_WIN_CYC,
  parameter CLK_HZ = `CLK_HZ
) (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] adr_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  input wire we_i,
  input wire [3:0] sel_i,
  input wire cyc_i,
  input wire stb_i,
  output wire ack_o,
  input wire aux_code_i,
  input wire [1:0] origin_done_i,
  input wire [1:0] ext_pulse_i,
  input wire [1:0] ext_dir_i,
  input wire enc_a_i,
  input wire enc_b_i,
  output reg [1:0] pulse_o,
  output reg [1:0] dir_o,
  output reg busy_o,
  output reg error_o,
  output reg step_start_o,
  output reg step_axis_o,
  output reg [7:0] step_no_o
);
  localparam [2:0] M_IDLE = 3'h0;
  localparam [2:0] M_INCH = 3'h1;
  localparam [2:0] M_SPD = 3'h2;
  localparam [2:0] M_POS = 3'h3;
  localparam [2:0] M_ESTOP = 3'h4;

  function [31:0] bmask;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        bmask[8*k +: 8] = sel[k] ? nw[8*k +: 8] : old[8*k +: 8];
      end
    end
  endfunction

  // ==========================================
  // Wishbone slave
  reg ack_reg;
  reg [31:0] cfg_reg, inch_amt_reg, inch_spd_reg, jog_acc_reg, jog_dec_reg, ratio_reg;
  reg [31:0] limit_reg, estop_dec_reg, sync_pos_reg, sync_step_reg, enc_max_reg, enc_min_reg;
  reg [15:0] err_reg;
  reg [2:0] mode_reg;
  reg aux_reg;
  reg signed [31:0] enc_cnt_reg;
  reg signed [31:0] pos_reg [0:1];
  reg [31:0] rd_mux;
  wire req = cyc_i & stb_i;
  wire wr_en = req & we_i & ack_reg;
  assign ack_o = ack_reg;
  wire [5:0] cmd = (wr_en && adr_i == `REG_CMD && sel_i[0]) ? dat_i[5:0] : 6'h00;
  wire cmd_axis = cfg_reg[`CFG_AXIS];
  wire [1:0] master = cfg_reg[`CFG_MASTER_LSB +: 2];
  wire [1:0] enc_mode = cfg_reg[`CFG_ENC_MODE_LSB +: 2];
  wire [15:0] main_ratio = ratio_reg[15:0];
  wire [15:0] sub_ratio = ratio_reg[31:16];

  always @* begin
    case (adr_i)
      `REG_CFG: rd_mux = cfg_reg;
      `REG_INCH_AMT: rd_mux = inch_amt_reg;
      `REG_INCH_SPEED: rd_mux = inch_spd_reg;
      `REG_JOG_ACC: rd_mux = jog_acc_reg;
      `REG_JOG_DEC: rd_mux = jog_dec_reg;
      `REG_RATIO: rd_mux = ratio_reg;
      `REG_SPEED_LIMIT: rd_mux = limit_reg;
      `REG_ESTOP_DEC: rd_mux = estop_dec_reg;
      `REG_SYNC_POS: rd_mux = sync_pos_reg;
      `REG_SYNC_STEP: rd_mux = sync_step_reg;
      `REG_ENC_MAX: rd_mux = enc_max_reg;
      `REG_ENC_MIN: rd_mux = enc_min_reg;
      `REG_STATUS: rd_mux = {26'h0, aux_reg, error_o, busy_o, mode_reg};
      `REG_ENC_COUNT: rd_mux = enc_cnt_reg;
      `REG_POS_X: rd_mux = pos_reg[0];
      `REG_POS_Y: rd_mux = pos_reg[1];
      `REG_ERR: rd_mux = {16'h0, err_reg};
      default: rd_mux = 32'h0;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_o <= 32'h0;
      cfg_reg <= 32'h0;
      inch_amt_reg <= 32'h0;
      inch_spd_reg <= {16'h0, `RST_INCH_SPEED};
      jog_acc_reg <= 32'h0;
      jog_dec_reg <= 32'h0;
      ratio_reg <= `RST_RATIO;
      limit_reg <= `RST_SPEED_LIMIT;
      estop_dec_reg <= 32'h0;
      sync_pos_reg <= 32'h0;
      sync_step_reg <= {24'h0, `RST_SYNC_STEP};
      enc_max_reg <= `RST_ENC_MAX;
      enc_min_reg <= `RST_ENC_MIN;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (req & ~ack_reg) begin
        dat_o <= rd_mux;
      end
      if (wr_en) begin
        case (adr_i)
          `REG_CFG: cfg_reg <= bmask(cfg_reg, dat_i, sel_i) & 32'h1f;
          `REG_INCH_AMT: inch_amt_reg <= bmask(inch_amt_reg, dat_i, sel_i);
          `REG_INCH_SPEED: inch_spd_reg <= bmask(inch_spd_reg, dat_i, sel_i) & 32'hffff;
          `REG_JOG_ACC: jog_acc_reg <= bmask(jog_acc_reg, dat_i, sel_i) & 32'hffff;
          `REG_JOG_DEC: jog_dec_reg <= bmask(jog_dec_reg, dat_i, sel_i) & 32'hffff;
          `REG_RATIO: ratio_reg <= bmask(ratio_reg, dat_i, sel_i);
          `REG_SPEED_LIMIT: limit_reg <= bmask(limit_reg, dat_i, sel_i);
          `REG_ESTOP_DEC: estop_dec_reg <= bmask(estop_dec_reg, dat_i, sel_i) & 32'hffff;
          `REG_SYNC_POS: sync_pos_reg <= bmask(sync_pos_reg, dat_i, sel_i);
          `REG_SYNC_STEP: sync_step_reg <= bmask(sync_step_reg, dat_i, sel_i) & 32'hff;
          `REG_ENC_MAX: enc_max_reg <= bmask(enc_max_reg, dat_i, sel_i);
          `REG_ENC_MIN: enc_min_reg <= bmask(enc_min_reg, dat_i, sel_i);
          default: ;
        endcase
      end
    end
  end

  // ==========================================
  // Encoder input, synchronised then decoded
  reg a1, a2, a3, b1, b2, b3;
  reg enc_ev, enc_dir;
  always @(posedge clk_i) begin
    if (rst_i) begin
      {a1, a2, a3, b1, b2, b3} <= 6'h0;
    end else begin
      {a3, a2, a1} <= {a2, a1, enc_a_i};
      {b3, b2, b1} <= {b2, b1, enc_b_i};
    end
  end

  always @* begin
    enc_ev = 1'b0;
    enc_dir = 1'b0;
    case (enc_mode)
      `ENC_UPDOWN: begin
        enc_ev = (a2 & ~a3) ^ (b2 & ~b3);
        enc_dir = b2 & ~b3;
      end
      `ENC_PULSE_DIR: begin
        enc_ev = a2 & ~a3;
        enc_dir = b2;
      end
      `ENC_QUAD4: begin
        enc_ev = (a2 ^ a3) ^ (b2 ^ b3);
        enc_dir = a3 ^ b2;
      end
      default: ;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      enc_cnt_reg <= 32'sh0;
    end else if (enc_ev) begin
      // Count held at the limits rather than wrapping
      if (!enc_dir && enc_cnt_reg < $signed(enc_max_reg)) begin
        enc_cnt_reg <= enc_cnt_reg + 32'sh1;
      end else if (enc_dir && enc_cnt_reg > $signed(enc_min_reg)) begin
        enc_cnt_reg <= enc_cnt_reg - 32'sh1;
      end
    end
  end

  // ==========================================
  // Pulse merge and axis positions
  reg gen_pulse, gen_dir;
  reg [1:0] ax_p, ax_d;
  integer i, j;
  always @* begin
    for (i = 0; i < 2; i = i + 1) begin
      ax_p[i] = ext_pulse_i[i] | (gen_pulse & (cmd_axis == i));
      ax_d[i] = (gen_pulse & (cmd_axis == i)) ? gen_dir : ext_dir_i[i];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      pulse_o <= 2'h0;
      dir_o <= 2'h0;
      pos_reg[0] <= 32'sh0;
      pos_reg[1] <= 32'sh0;
    end else begin
      pulse_o <= ax_p;
      dir_o <= ax_d;
      for (j = 0; j < 2; j = j + 1) begin
        if (ax_p[j]) begin
          pos_reg[j] <= ax_d[j] ? pos_reg[j] - 32'sh1 : pos_reg[j] + 32'sh1;
        end
      end
    end
  end

  // ==========================================
  // Master selection and rate measurement
  wire m_ev = (master == `MASTER_ENC) ? enc_ev : ext_pulse_i[master[0]];
  wire m_dir = (master == `MASTER_ENC) ? enc_dir : ext_dir_i[master[0]];
  wire master_bad = (master > `MASTER_ENC) || (master[1] == 1'b0 && master[0] == cmd_axis);
  wire signed [31:0] m_pos = pos_reg[master[0]];
  reg [31:0] win_cnt, m_cnt, s_cnt, s_rate;
  always @(posedge clk_i) begin
    if (rst_i) begin
      win_cnt <= 32'h0;
      m_cnt <= 32'h0;
      s_cnt <= 32'h0;
      s_rate <= 32'h0;
    end else if (win_cnt == RATE_WIN_CYC - 1) begin
      win_cnt <= 32'h0;
      m_cnt <= 32'h0;
      s_cnt <= 32'h0;
      s_rate <= s_cnt;
    end else begin
      win_cnt <= win_cnt + 32'h1;
      m_cnt <= m_cnt + {31'h0, m_ev};
      s_cnt <= s_cnt + {31'h0, gen_pulse};
    end
  end
  wire overspeed = m_ev && (m_cnt >= limit_reg);

  // ==========================================
  // Ramp and pulse generator
  reg [31:0] cur_spd, goal_spd, ramp_amt, estop_spd, rem;
  reg [15:0] ramp_time;
  reg [47:0] racc;
  reg [32:0] phase;
  reg [16:0] acc_ratio;
  reg stop_req, decel;
  reg signed [31:0] prev_pos;
  wire [47:0] ramp_lim = ramp_time * MS_CYC;
  // Stop distance test, both sides scaled to avoid a divider
  wire [63:0] dist_have = rem * `DIST_SCALE * inch_spd_reg[15:0];
  wire [63:0] dist_need = cur_spd[16:0] * cur_spd[16:0] * jog_dec_reg[15:0];
  always @* begin
    decel = stop_req || (dist_have <= dist_need);
    goal_spd = 32'h0;
    ramp_time = estop_dec_reg[15:0];
    ramp_amt = estop_spd;
    if (mode_reg == M_INCH) begin
      goal_spd = decel ? 32'h1 : inch_spd_reg;
      ramp_time = decel ? jog_dec_reg[15:0] : jog_acc_reg[15:0];
      ramp_amt = inch_spd_reg;
    end
  end
  wire gen_on = (mode_reg == M_INCH) || (mode_reg == M_ESTOP);
  wire [32:0] phase_sum = phase + {1'b0, cur_spd};
  wire [47:0] racc_sum = racc + {16'h0, ramp_amt};
  wire inch_bad = (inch_spd_reg == 32'h0);
  // Crossing test covers a position jumped over between scans
  wire crossed = (prev_pos <= $signed(sync_pos_reg) && $signed(sync_pos_reg) <= m_pos) ||
                 (m_pos <= $signed(sync_pos_reg) && $signed(sync_pos_reg) <= prev_pos);

  // ==========================================
  // Command sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg <= M_IDLE;
      err_reg <= 16'h0;
      error_o <= 1'b0;
      busy_o <= 1'b0;
      aux_reg <= 1'b0;
      cur_spd <= 32'h0;
      estop_spd <= 32'h0;
      rem <= 32'h0;
      racc <= 48'h0;
      phase <= 33'h0;
      acc_ratio <= 17'h0;
      stop_req <= 1'b0;
      gen_pulse <= 1'b0;
      gen_dir <= 1'b0;
      prev_pos <= 32'sh0;
      step_start_o <= 1'b0;
      step_axis_o <= 1'b0;
      step_no_o <= 8'h0;
    end else begin
      gen_pulse <= 1'b0;
      step_start_o <= 1'b0;
      prev_pos <= m_pos;
      busy_o <= (mode_reg != M_IDLE);
      error_o <= (err_reg != 16'h0);
      // Clear first so a new event in the same cycle wins
      if (wr_en && adr_i == `REG_ERR) begin
        err_reg <= 16'h0;
      end
      if (cmd[`CMD_AUX_RELEASE]) begin
        aux_reg <= 1'b0;
      end
      if (aux_code_i) begin
        aux_reg <= 1'b1;
      end
      if (gen_on) begin
        if (ramp_time == 16'h0) begin
          cur_spd <= goal_spd;
        end else if (cur_spd != goal_spd) begin
          if (racc_sum >= ramp_lim) begin
            racc <= racc_sum - ramp_lim;
            cur_spd <= (cur_spd < goal_spd) ? cur_spd + 32'h1 : cur_spd - 32'h1;
          end else begin
            racc <= racc_sum;
          end
        end
        if (phase_sum >= CLK_HZ) begin
          phase <= phase_sum - CLK_HZ;
          gen_pulse <= 1'b1;
          rem <= rem - 32'h1;
        end else begin
          phase <= phase_sum;
        end
      end
      case (mode_reg)
        M_IDLE: begin
          racc <= 48'h0;
          phase <= 33'h0;
          cur_spd <= 32'h0;
          stop_req <= 1'b0;
          if (cmd[`CMD_INCH]) begin
            if (inch_bad) begin
              err_reg <= `ERR_INCH_SPEED;
            end else if (inch_amt_reg != 32'h0) begin
              mode_reg <= M_INCH;
              gen_dir <= inch_amt_reg[31];
              rem <= inch_amt_reg[31] ? (~inch_amt_reg + 32'h1) : inch_amt_reg;
            end
          end else if (cmd[`CMD_SPD_SYNC]) begin
            if (aux_reg) begin
              err_reg <= `ERR_AUX_ON_SPD;
            end else if (master_bad) begin
              err_reg <= `ERR_MASTER;
            end else begin
              mode_reg <= M_SPD;
              acc_ratio <= 17'h0;
            end
          end else if (cmd[`CMD_POS_SYNC]) begin
            if (aux_reg) begin
              err_reg <= `ERR_AUX_ON_POS;
            end else if (master[1] || master[0] == cmd_axis) begin
              err_reg <= `ERR_MASTER;
            end else if (!origin_done_i[master[0]]) begin
              err_reg <= `ERR_NO_ORIGIN;
            end else begin
              mode_reg <= M_POS;
            end
          end
        end
        M_INCH: begin
          if (cmd[`CMD_STOP]) begin
            stop_req <= 1'b1;
          end
          if (rem == 32'h0 || (rem == 32'h1 && phase_sum >= CLK_HZ)) begin
            mode_reg <= M_IDLE;
          end
        end
        M_SPD: begin
          // Nothing moves until the master itself moves
          if (overspeed) begin
            err_reg <= `ERR_OVERSPEED;
            estop_spd <= s_rate;
            cur_spd <= s_rate;
            racc <= 48'h0;
            phase <= 33'h0;
            rem <= 32'hffff_ffff;
            mode_reg <= M_ESTOP;
          end else if (cmd[`CMD_SYNC_RELEASE] || cmd[`CMD_STOP]) begin
            mode_reg <= M_IDLE;
          end else begin
            // One sub pulse per main_ratio worth of sub_ratio credit
            if (acc_ratio >= {1'b0, main_ratio}) begin
              gen_pulse <= 1'b1;
              acc_ratio <= acc_ratio - {1'b0, main_ratio} +
                           (m_ev ? {1'b0, sub_ratio} : 17'h0);
            end else if (m_ev) begin
              acc_ratio <= acc_ratio + {1'b0, sub_ratio};
            end
            if (m_ev) begin
              gen_dir <= m_dir;
            end
          end
        end
        M_POS: begin
          if (cmd[`CMD_STOP]) begin
            mode_reg <= M_IDLE;
          end else if (crossed) begin
            step_start_o <= 1'b1;
            step_axis_o <= cmd_axis;
            step_no_o <= sync_step_reg[7:0];
            mode_reg <= M_IDLE;
          end
        end
        M_ESTOP: begin
          if (cur_spd == 32'h0) begin
            mode_reg <= M_IDLE;
          end
        end
        default: mode_reg <= M_IDLE;
      endcase
    end
  end
endmodule // axis_inching_and_sync_control

//--- axis_sync_properties.sv
`timescale 1ns/1ps
`include "axis_sync_map.vh"
module axis_sync_checker (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] adr_i,
  input wire [31:0] dat_i,
  input wire we_i,
  input wire [3:0] sel_i,
  input wire cyc_i,
  input wire stb_i,
  input wire ack_o,
  input wire aux_code_i,
  input wire [1:0] origin_done_i,
  input wire [1:0] ext_pulse_i,
  input wire [1:0] ext_dir_i,
  input wire [1:0] pulse_o,
  input wire [1:0] dir_o,
  input wire busy_o,
  input wire error_o,
  input wire step_start_o
);
  // ==========================================
  // Bus snooping
  wire wr = ack_o & cyc_i & stb_i & we_i;
  wire wr_cmd = wr & sel_i[0] & (adr_i == `REG_CMD);
  reg aux_reg;
  reg pend_reg;
  reg [2:0] cfg_reg;
  reg [15:0] speed_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      aux_reg <= 1'b0;
      pend_reg <= 1'b0;
      cfg_reg <= 3'h0;
      speed_reg <= `RST_INCH_SPEED;
    end else begin
      // Set wins over clear, as in the flag itself
      if (aux_code_i) aux_reg <= 1'b1;
      else if (wr_cmd & dat_i[`CMD_AUX_RELEASE]) aux_reg <= 1'b0;
      if (wr_cmd & dat_i[`CMD_POS_SYNC] & !busy_o) pend_reg <= 1'b1;
      else if (step_start_o | (wr_cmd & dat_i[`CMD_STOP])) pend_reg <= 1'b0;
      if (wr & sel_i[0] & (adr_i == `REG_CFG)) cfg_reg <= dat_i[2:0];
      if (wr & (adr_i == `REG_INCH_SPEED)) speed_reg <= dat_i[15:0];
    end
  end
  // ==========================================
  // Properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_quiet;
    (!busy_o && !step_start_o) [*6];
  endsequence
  sequence s_err;
    ##[1:4] error_o;
  endsequence
  ack_single_a: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered next cycle");
  ext_pass_a: assert property (ext_pulse_i[0] |=> pulse_o[0] && dir_o[0] == $past(ext_dir_i[0]))
    else $error("main axis pulse not passed on");
  start_pulse_a: assert property (step_start_o |=> !step_start_o)
    else $error("start pulse too long");
  start_busy_a: assert property (step_start_o |-> $past(busy_o))
    else $error("start without pending state");
  inch_speed_a: assert property (wr_cmd && dat_i[`CMD_INCH] && speed_reg == 16'h0 && !busy_o
    |-> s_err)
    else $error("zero inching speed accepted");
  aux_refuse_a: assert property (wr_cmd && dat_i[`CMD_SPD_SYNC] && aux_reg && !busy_o
    |-> s_err)
    else $error("speed sync accepted with aux code on");
  origin_need_a: assert property (wr_cmd && dat_i[`CMD_POS_SYNC] && !busy_o
    && !origin_done_i[cfg_reg[1]] |-> s_err)
    else $error("position sync without origin accepted");
  stop_cancel_a: assert property (wr_cmd && dat_i[`CMD_STOP] && pend_reg
    |-> ##[1:4] s_quiet)
    else $error("stop did not cancel pending start");
endmodule // axis_sync_checker
bind axis_inching_and_sync_control axis_sync_checker chk (.clk_i(clk_i), .rst_i(rst_i),
  .adr_i(adr_i), .dat_i(dat_i), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .aux_code_i(aux_code_i), .origin_done_i(origin_done_i),
  .ext_pulse_i(ext_pulse_i), .ext_dir_i(ext_dir_i), .pulse_o(pulse_o), .dir_o(dir_o),
  .busy_o(busy_o), .error_o(error_o), .step_start_o(step_start_o));

//--- axis_far_side.sv
`timescale 1ns/1ps
module axis_far_side (
  input wire clk_i,
  output reg [1:0] pulse_o,
  output reg [1:0] dir_o,
  output reg a_o,
  output reg b_o
);
  reg [1:0] ph = 2'h0;
  initial begin
    pulse_o = 2'h0;
    dir_o = 2'h0;
    a_o = 1'b0;
    b_o = 1'b0;
  end
  // ==========================================
  // Main axis engine, X only; gap sets how slowly it moves
  task move(input rev, input integer n, input integer gap);
    integer i;
    for (i = 0; i < n; i = i + 1) begin
      @(posedge clk_i);
      dir_o[0] <= rev;
      pulse_o[0] <= 1'b1;
      @(posedge clk_i);
      pulse_o[0] <= 1'b0;
      repeat (gap) @(posedge clk_i);
    end
  endtask
  // ==========================================
  // Encoder; slow enough for the pin synchronisers
  task quad(input rev, input integer n);
    integer i;
    for (i = 0; i < n; i = i + 1) begin
      ph = rev ? ph - 2'h1 : ph + 2'h1;
      @(posedge clk_i);
      a_o <= ph[0] ^ ph[1];
      b_o <= ph[1];
      repeat (6) @(posedge clk_i);
    end
  endtask
  task pulse_a(input integer n);
    integer i;
    for (i = 0; i < 2 * n; i = i + 1) begin
      @(posedge clk_i);
      a_o <= ~a_o;
      repeat (6) @(posedge clk_i);
    end
  endtask
endmodule // axis_far_side

//--- axis_inching_and_sync_control_tb_top.sv
`timescale 1ns/1ps
`include "axis_sync_map.vh"
module axis_inching_and_sync_control_tb_top;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg [7:0] adr_i = 8'h00;
  reg [31:0] dat_i = 32'h0;
  reg [3:0] sel_i = 4'h0;
  reg we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, aux_code_i = 1'b0;
  reg [1:0] origin_done_i = 2'h0;
  wire [31:0] dat_o;
  wire [7:0] step_no_o;
  wire [1:0] pulse_o, dir_o, ext_pulse_i, ext_dir_i;
  wire ack_o, busy_o, error_o, step_start_o, step_axis_o, enc_a_i, enc_b_i;
  integer errors = 0, total_checks = 0, cycles = 0, np0 = 0, np1 = 0, ns = 0, a;
  reg [31:0] rd, s;
  reg d0, d1, sax;
  reg [7:0] sno;
  initial forever #10 clk_i = ~clk_i;
  axis_inching_and_sync_control #(.MS_CYC(10), .RATE_WIN_CYC(1000)) uut (.clk_i(clk_i),
    .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .aux_code_i(aux_code_i),
    .origin_done_i(origin_done_i), .ext_pulse_i(ext_pulse_i), .ext_dir_i(ext_dir_i),
    .enc_a_i(enc_a_i), .enc_b_i(enc_b_i), .pulse_o(pulse_o), .dir_o(dir_o), .busy_o(busy_o),
    .error_o(error_o), .step_start_o(step_start_o), .step_axis_o(step_axis_o),
    .step_no_o(step_no_o));
  axis_far_side p (.clk_i(clk_i), .pulse_o(ext_pulse_i), .dir_o(ext_dir_i), .a_o(enc_a_i),
    .b_o(enc_b_i));
  // ==========================================
  // Output monitors and hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (pulse_o[0] === 1'b1) begin np0 <= np0 + 1; d0 <= dir_o[0]; end
    if (pulse_o[1] === 1'b1) begin np1 <= np1 + 1; d1 <= dir_o[1]; end
    if (step_start_o === 1'b1) begin ns <= ns + 1; sno <= step_no_o; sax <= step_axis_o; end
    if (cycles == 90000) begin errors = errors + 1; wrap_up; end
  end
  // ==========================================
  // Tasks
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wb(input [7:0] ad, input w, input [31:0] d);
    integer t;
    @(posedge clk_i);
    adr_i <= ad; we_i <= w; dat_i <= d; sel_i <= 4'hf; cyc_i <= 1'b1; stb_i <= 1'b1;
    t = 0;
    do begin @(posedge clk_i); t = t + 1; end while (ack_o !== 1'b1 && t < 50);
    rd = dat_o;
    if (t >= 50) errors = errors + 1;
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
  endtask
  task rc(input [7:0] ad, input [31:0] exp, input string nm);
    wb(ad, 1'b0, 32'h0);
    chk(nm, rd, exp);
  endtask
  task cmd(input integer b);
    wb(`REG_CMD, 1'b1, 32'h1 << b);
  endtask
  task idle(input integer n);
    integer t;
    t = 0;
    // Busy rises two edges after the command's ack
    repeat (2) @(posedge clk_i);
    while (busy_o !== 1'b0 && t < n) begin @(posedge clk_i); t = t + 1; end
    // Let the monitor count the final pulse
    @(posedge clk_i);
    chk("busy", {31'h0, busy_o}, 32'h0);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(`REG_RATIO, `RST_RATIO, "ratio");
    rc(`REG_INCH_SPEED, {16'h0, `RST_INCH_SPEED}, "inch speed");
    rc(`REG_ENC_MAX, `RST_ENC_MAX, "enc max");
    rc(`REG_ENC_MIN, `RST_ENC_MIN, "enc min");
    rc(`REG_SYNC_STEP, {24'h0, `RST_SYNC_STEP}, "step");
    rc(8'h48, 32'h0, "unmapped");
    wb(`REG_STATUS, 1'b1, 32'hffffffff);
    rc(`REG_STATUS, 32'h0, "status");
    // Ramp times 0 jump straight to speed, keeping the run short
    wb(`REG_INCH_SPEED, 1'b1, 32'h0000ffff);
    wb(`REG_INCH_AMT, 1'b1, 32'h3);
    a = np0; cmd(`CMD_INCH); idle(20000);
    chk("fwd pulses", np0 - a, 3);
    chk("fwd dir", {31'h0, d0}, 0);
    wb(`REG_INCH_AMT, 1'b1, 32'hfffffffe);
    a = np0; cmd(`CMD_INCH); idle(20000);
    chk("rev pulses", np0 - a, 2);
    chk("rev dir", {31'h0, d0}, 1);
    rc(`REG_POS_X, 32'h1, "pos x");
    wb(`REG_INCH_SPEED, 1'b1, 32'h0);
    a = np0; cmd(`CMD_INCH); repeat (100) @(posedge clk_i);
    chk("no move", np0 - a, 0);
    rc(`REG_ERR, {16'h0, `ERR_INCH_SPEED}, "err speed");
    wb(`REG_ERR, 1'b1, 32'h0);
    @(posedge clk_i) aux_code_i <= 1'b1;
    @(posedge clk_i) aux_code_i <= 1'b0;
    wb(`REG_CFG, 1'b1, 32'h1);
    cmd(`CMD_SPD_SYNC);
    rc(`REG_ERR, {16'h0, `ERR_AUX_ON_SPD}, "err aux");
    cmd(`CMD_AUX_RELEASE); wb(`REG_ERR, 1'b1, 32'h0);
    wb(`REG_CFG, 1'b1, 32'h3); cmd(`CMD_SPD_SYNC);
    rc(`REG_ERR, {16'h0, `ERR_MASTER}, "err master");
    wb(`REG_ERR, 1'b1, 32'h0);
    wb(`REG_CFG, 1'b1, 32'h1); wb(`REG_RATIO, 1'b1, 32'h00010002);
    cmd(`CMD_SPD_SYNC);
    a = np1; p.move(1'b0, 8, 8); repeat (20) @(posedge clk_i);
    chk("sync fwd", np1 - a, 4);
    chk("sync dir", {31'h0, d1}, 0);
    chk("sync busy", {31'h0, busy_o}, 1);
    a = np1; p.move(1'b1, 4, 8); repeat (20) @(posedge clk_i);
    chk("sync rev", np1 - a, 2);
    chk("sync rdir", {31'h0, d1}, 1);
    cmd(`CMD_SYNC_RELEASE); idle(2000);
    wb(`REG_SPEED_LIMIT, 1'b1, 32'h3); cmd(`CMD_SPD_SYNC);
    // Eight pulses so that one rate window always holds four
    p.move(1'b0, 8, 2); repeat (20) @(posedge clk_i);
    rc(`REG_ERR, {16'h0, `ERR_OVERSPEED}, "err speed lim");
    cmd(`CMD_SYNC_RELEASE); idle(5000); wb(`REG_ERR, 1'b1, 32'h0);
    wb(`REG_SPEED_LIMIT, 1'b1, `RST_SPEED_LIMIT);
    wb(`REG_CFG, 1'b1, 32'h14); wb(`REG_RATIO, 1'b1, 32'h00010001); cmd(`CMD_SPD_SYNC);
    a = np0; repeat (50) @(posedge clk_i);
    chk("enc wait", np0 - a, 0);
    p.quad(1'b0, 8); repeat (20) @(posedge clk_i);
    chk("enc follow", np0 - a, 8);
    rc(`REG_ENC_COUNT, 32'h8, "quad up");
    p.quad(1'b1, 4);
    rc(`REG_ENC_COUNT, 32'h4, "quad down");
    cmd(`CMD_SYNC_RELEASE); idle(2000);
    wb(`REG_ENC_MAX, 1'b1, 32'h6); p.quad(1'b0, 8);
    rc(`REG_ENC_COUNT, 32'h6, "clamp");
    wb(`REG_ENC_MAX, 1'b1, `RST_ENC_MAX); wb(`REG_CFG, 1'b1, 32'h4); p.pulse_a(3);
    rc(`REG_ENC_COUNT, 32'h9, "up count");
    wb(`REG_CFG, 1'b1, 32'h1); cmd(`CMD_POS_SYNC);
    rc(`REG_ERR, {16'h0, `ERR_NO_ORIGIN}, "err origin");
    wb(`REG_ERR, 1'b1, 32'h0); origin_done_i <= 2'h1;
    wb(`REG_POS_X, 1'b0, 32'h0); s = rd;
    wb(`REG_SYNC_POS, 1'b1, s + 3); wb(`REG_SYNC_STEP, 1'b1, 32'h96);
    a = ns; cmd(`CMD_POS_SYNC); p.move(1'b0, 2, 8);
    chk("no early", ns - a, 0);
    chk("pend busy", {31'h0, busy_o}, 1);
    p.move(1'b0, 2, 8);
    chk("started", ns - a, 1);
    chk("step no", {24'h0, sno}, 32'h96);
    chk("step axis", {31'h0, sax}, 1);
    idle(2000); wb(`REG_SYNC_POS, 1'b1, s + 10);
    a = ns; cmd(`CMD_POS_SYNC); p.move(1'b0, 1, 8); cmd(`CMD_STOP);
    p.move(1'b0, 12, 8); idle(100);
    chk("cancel", ns - a, 0);
    wrap_up;
  end
endmodule // axis_inching_and_sync_control_tb_top
